// ===== hdl/rsc_pkg.sv
// Package for the reset strap capture block
package rsc_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int SETTLE_NS      = 100;
   localparam int SETTLE_CYCLES  =
      (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_STAGES    = 2;

   // ==========================================================
   // Strap bus field positions
   // ==========================================================
   localparam int STRAP_W        = 16;
   localparam int PORT_W         = 4;
   localparam int BIT_DEBOUNCE   = 0;
   localparam int BIT_RSV_LO     = 1;
   localparam int BIT_RSV_HI     = 2;
   localparam int BIT_MGMT_MODE  = 3;
   localparam int BIT_ID_LSB     = 4;
   localparam int ID_W           = 3;
   localparam int BIT_NO_EEPROM  = 7;
   localparam int BIT_MFG_LO     = 8;
   localparam int BIT_MOD_DETECT = 9;
   localparam int BIT_RSV_LOW    = 10;
   localparam int BIT_PWR_SAVE   = 11;
   localparam int BIT_TO_RESET   = 12;
   localparam int BIT_MFG_HI_LSB = 13;
   localparam int MFG_HI_W       = 3;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] ADDR_CFG   = 8'h00;
   localparam logic [7:0] ADDR_USER  = 8'h04;
   localparam logic [7:0] ADDR_RAW   = 8'h08;
   localparam logic [7:0] ADDR_CTRL  = 8'h0c;
   localparam logic [7:0] ADDR_STAT  = 8'h10;
   localparam int CTRL_STAT_DRIVE    = 0;
   localparam int CTRL_TX_DRIVE      = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int STAT_CAPTURED      = 0;
   localparam int STAT_BOARD_FAULT   = 1;
   localparam int STAT_DRIVING       = 2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic             debounce_en;
      logic             unmanaged;
      logic [ID_W-1:0]  device_id;
      logic             eeprom_absent;
      logic             module_detect_en;
      logic             power_save_en;
      logic             timeout_reset_en;
      logic [PORT_W-1:0] user_strap;
   } rsc_cfg_t;

   typedef struct packed {
      logic checksum_good;
      logic init_done;
      logic mem_test_busy;
      logic init_started;
   } rsc_init_status_t;

endpackage

// ===== hdl/rsc_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module rsc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   generate
      if (W < 1) begin : g_bad_w
         $error("W must be at least 1");
      end
   endgenerate

   // ==========================================================
   // Per-bit stages
   // ==========================================================
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               q[i]    <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate

endmodule

// ===== hdl/rsc_top.sv
// Reset strap capture with APB readback
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module rsc_top #(
   parameter int SETTLE = rsc_pkg::SETTLE_CYCLES
) (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [7:0]                       paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic [rsc_pkg::STRAP_W-1:0]      strap_status_bus_in,
   output logic      [rsc_pkg::STRAP_W-1:0]      strap_status_bus_out,
   output logic      [rsc_pkg::STRAP_W-1:0]      strap_status_bus_oe_n,
   input  wire logic [rsc_pkg::PORT_W-1:0]       port_tx_enable_in,
   output logic      [rsc_pkg::PORT_W-1:0]       port_tx_enable_out,
   output logic      [rsc_pkg::PORT_W-1:0]       port_tx_enable_oe_n,
   input  wire logic [rsc_pkg::PORT_W-1:0]       port_tx_enable_func,
   input  wire rsc_pkg::rsc_init_status_t        init_status,
   output rsc_pkg::rsc_cfg_t                     cfg,
   output logic                                  cfg_valid
);

   // ==========================================================
   // Parameter check
   // ==========================================================
   generate
      if (SETTLE < rsc_pkg::SYNC_STAGES || SETTLE > 255) begin : g_bad_settle
         $error("SETTLE must lie in 2..255");
      end
      if (rsc_pkg::STRAP_W != 16 || rsc_pkg::PORT_W != 4) begin : g_bad_width
         $error("Pin widths fixed at 16 and 4");
      end
      if ($bits(rsc_pkg::rsc_cfg_t) > 32) begin : g_bad_cfg
         $error("Config word wider than the data bus");
      end
   endgenerate

   typedef enum logic [1:0] {
      ST_WAIT,
      ST_SAMPLE,
      ST_RUN
   } rsc_state_t;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [rsc_pkg::STRAP_W-1:0] strap_sync;
   logic [rsc_pkg::PORT_W-1:0]  port_sync;

   rsc_sync #(
      .W (rsc_pkg::STRAP_W)
   ) u_sync_strap (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (strap_status_bus_in),
      .q     (strap_sync)
   );

   rsc_sync #(
      .W (rsc_pkg::PORT_W)
   ) u_sync_port (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (port_tx_enable_in),
      .q     (port_sync)
   );

   // ==========================================================
   // Capture sequencer
   // ==========================================================
   rsc_state_t                   state;
   rsc_state_t                   next_state;
   logic [7:0]                   cnt;
   logic [7:0]                   next_cnt;
   logic [rsc_pkg::STRAP_W-1:0]  raw;
   logic [rsc_pkg::STRAP_W-1:0]  next_raw;
   logic [rsc_pkg::PORT_W-1:0]   user;
   logic [rsc_pkg::PORT_W-1:0]   next_user;
   logic [7:0]                   settle_last;

   assign settle_last = 8'(SETTLE - 1);

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_raw   = raw;
      next_user  = user;
      case (state)
         ST_WAIT: begin
            if (cnt == settle_last) begin
               next_state = ST_SAMPLE;
            end else begin
               next_cnt = cnt + 8'h01;
            end
         end
         ST_SAMPLE: begin
            next_raw   = strap_sync;
            next_user  = port_sync;
            next_state = ST_RUN;
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_WAIT;
            next_cnt   = 8'h00;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_WAIT;
         cnt   <= 8'h00;
         raw   <= 16'h0000;
         user  <= 4'h0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         raw   <= next_raw;
         user  <= next_user;
      end
   end

   // ==========================================================
   // Strap decode
   // ==========================================================
   logic board_fault;

   always_comb begin
      cfg.debounce_en      = raw[rsc_pkg::BIT_DEBOUNCE];
      cfg.unmanaged        = raw[rsc_pkg::BIT_MGMT_MODE];
      cfg.device_id        =
         raw[rsc_pkg::BIT_ID_LSB +: rsc_pkg::ID_W];
      cfg.eeprom_absent    = raw[rsc_pkg::BIT_NO_EEPROM];
      cfg.module_detect_en = raw[rsc_pkg::BIT_MOD_DETECT];
      cfg.power_save_en    = raw[rsc_pkg::BIT_PWR_SAVE];
      cfg.timeout_reset_en = raw[rsc_pkg::BIT_TO_RESET];
      cfg.user_strap       = user;
   end

   always_comb begin
      board_fault = 1'b0;
      if (!raw[rsc_pkg::BIT_RSV_LO] || !raw[rsc_pkg::BIT_RSV_HI]) begin
         board_fault = 1'b1;
      end
      if (!raw[rsc_pkg::BIT_MFG_LO]) begin
         board_fault = 1'b1;
      end
      if (raw[rsc_pkg::BIT_MFG_HI_LSB +: rsc_pkg::MFG_HI_W] != 3'h7) begin
         board_fault = 1'b1;
      end
      if (raw[rsc_pkg::BIT_RSV_LOW]) begin
         board_fault = 1'b1;
      end
      if (state != ST_RUN) begin
         board_fault = 1'b0;
      end
   end

   assign cfg_valid = (state == ST_RUN);

   // ==========================================================
   // Control register and APB slave
   // ==========================================================
   logic [1:0]  ctrl;
   logic [1:0]  next_ctrl;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        setup;
   logic        wr_access;

   assign pready    = psel & penable;
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite;

   always_comb begin
      next_ctrl    = ctrl;
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (wr_access && paddr == rsc_pkg::ADDR_CTRL) begin
         next_ctrl = pwdata[1:0];
      end
      if (setup) begin
         next_prdata  = 32'h0000_0000;
         next_pslverr = 1'b0;
         case (paddr)
            rsc_pkg::ADDR_CFG: begin
               next_prdata[$bits(rsc_pkg::rsc_cfg_t)-1:0] = cfg;
            end
            rsc_pkg::ADDR_USER: begin
               next_prdata[rsc_pkg::PORT_W-1:0] = user;
            end
            rsc_pkg::ADDR_RAW: begin
               next_prdata[rsc_pkg::STRAP_W-1:0] = raw;
            end
            rsc_pkg::ADDR_CTRL: begin
               next_prdata[1:0] = ctrl;
            end
            rsc_pkg::ADDR_STAT: begin
               next_prdata[rsc_pkg::STAT_CAPTURED]    = cfg_valid;
               next_prdata[rsc_pkg::STAT_BOARD_FAULT] = board_fault;
               next_prdata[rsc_pkg::STAT_DRIVING]     =
                  ~strap_status_bus_oe_n[0];
            end
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= rsc_pkg::CTRL_RESET;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ==========================================================
   // Shared pin drive
   // ==========================================================
   logic [rsc_pkg::STRAP_W-1:0] next_bus_out;
   logic [rsc_pkg::STRAP_W-1:0] next_bus_oe_n;
   logic [rsc_pkg::PORT_W-1:0]  next_tx_out;
   logic [rsc_pkg::PORT_W-1:0]  next_tx_oe_n;

   always_comb begin
      next_bus_out  = 16'h0000;
      next_bus_oe_n = 16'hffff;
      next_tx_out   = 4'h0;
      next_tx_oe_n  = 4'hf;
      if (state == ST_RUN) begin
         next_bus_out[3:0] = init_status;
         if (ctrl[rsc_pkg::CTRL_STAT_DRIVE]) begin
            next_bus_oe_n = 16'h0000;
         end
         next_tx_out = port_tx_enable_func;
         if (ctrl[rsc_pkg::CTRL_TX_DRIVE]) begin
            next_tx_oe_n = 4'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_status_bus_out  <= 16'h0000;
         strap_status_bus_oe_n <= 16'hffff;
         port_tx_enable_out    <= 4'h0;
         port_tx_enable_oe_n   <= 4'hf;
      end else begin
         strap_status_bus_out  <= next_bus_out;
         strap_status_bus_oe_n <= next_bus_oe_n;
         port_tx_enable_out    <= next_tx_out;
         port_tx_enable_oe_n   <= next_tx_oe_n;
      end
   end

endmodule

// ===== dv/rsc_board.sv
// Board strap resistors on the shared pins
`timescale 1ns/1ps
module rsc_board (
   input  wire logic [15:0] pull_s,
   input  wire logic [15:0] s_out,
   input  wire logic [15:0] s_oe_n,
   output logic      [15:0] s_pin,
   input  wire logic [3:0]  pull_t,
   input  wire logic [3:0]  t_out,
   input  wire logic [3:0]  t_oe_n,
   output logic      [3:0]  t_pin
);
   assign s_pin = (s_oe_n & pull_s) | (~s_oe_n & s_out);
   assign t_pin = (t_oe_n & pull_t) | (~t_oe_n & t_out);
endmodule

// ===== dv/rsc_top_chk.sv
// Assertion checker for the strap capture block
`timescale 1ns/1ps
module rsc_top_chk #(
   parameter int SETTLE = 20
) (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic [15:0]               strap_status_bus_in,
   input wire logic [15:0]               strap_status_bus_out,
   input wire logic [15:0]               strap_status_bus_oe_n,
   input wire logic [3:0]                port_tx_enable_in,
   input wire logic [3:0]                port_tx_enable_out,
   input wire logic [3:0]                port_tx_enable_oe_n,
   input wire logic [3:0]                port_tx_enable_func,
   input wire rsc_pkg::rsc_init_status_t init_status,
   input wire rsc_pkg::rsc_cfg_t         cfg,
   input wire logic                      cfg_valid
);
   logic [8:0] cap_cnt;
   logic [8:0] next_cap_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ============================================
   // Cycles from reset release to capture
   always_comb begin
      next_cap_cnt = cfg_valid ? cap_cnt : cap_cnt + 9'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_cnt <= 9'h0;
      end else begin
         cap_cnt <= next_cap_cnt;
      end
   end
   sequence s_capture;
      $rose(cfg_valid);
   endsequence
   sequence s_drive_on;
      strap_status_bus_oe_n[0] ##1 !strap_status_bus_oe_n[0];
   endsequence
   // ============================================
   // Capture, hold and pin drive
   a_debounce_cap: assert property (s_capture |->
      cfg.debounce_en == $past(strap_status_bus_in[0], 3))
      else $error("debounce strap wrong");
   a_mode_cap: assert property (s_capture |->
      cfg.unmanaged == $past(strap_status_bus_in[3], 3))
      else $error("mode strap wrong");
   a_id_cap: assert property (s_capture |->
      cfg.device_id == $past(strap_status_bus_in[6:4], 3))
      else $error("device id wrong");
   a_eeprom_cap: assert property (s_capture |->
      cfg.eeprom_absent == $past(strap_status_bus_in[7], 3))
      else $error("eeprom strap wrong");
   a_detect_cap: assert property (s_capture |->
      cfg.module_detect_en == $past(strap_status_bus_in[9], 3))
      else $error("detect strap wrong");
   a_power_cap: assert property (s_capture |->
      cfg.power_save_en == $past(strap_status_bus_in[11], 3))
      else $error("power strap wrong");
   a_timeout_cap: assert property (s_capture |->
      cfg.timeout_reset_en == $past(strap_status_bus_in[12], 3))
      else $error("timeout strap wrong");
   a_user_cap: assert property (s_capture |->
      cfg.user_strap == $past(port_tx_enable_in, 3))
      else $error("user strap wrong");
   a_capture_time: assert property (s_capture |->
      cap_cnt == SETTLE + 1) else $error("capture late or early");
   a_cfg_hold: assert property (cfg_valid |=>
      cfg_valid && $stable(cfg)) else $error("config changed");
   a_pins_released: assert property (!cfg_valid |->
      &strap_status_bus_oe_n && &port_tx_enable_oe_n)
      else $error("pin driven early");
   a_drive_start: assert property (s_capture |->
      s_drive_on)
      else $error("status drive timing");
   a_status_out: assert property (!strap_status_bus_oe_n[0] |->
      strap_status_bus_out[3:0] == $past(init_status))
      else $error("status output wrong");
   a_tx_func: assert property (!port_tx_enable_oe_n[0] |->
      port_tx_enable_out == $past(port_tx_enable_func))
      else $error("tx pin output wrong");
endmodule

bind rsc_top rsc_top_chk #(.SETTLE(SETTLE)) rsc_top_chk_inst (
   .pclk, .presetn, .strap_status_bus_in, .strap_status_bus_out,
   .strap_status_bus_oe_n, .port_tx_enable_in, .port_tx_enable_out,
   .port_tx_enable_oe_n, .port_tx_enable_func, .init_status, .cfg,
   .cfg_valid);

// ===== dv/tb.sv
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
module tb;
   localparam int SETTLE = 2;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] pull_s = 16'he106;
   logic [15:0] s_out, s_oe_n, s_pin;
   logic [3:0]  pull_t = 4'h0;
   logic [3:0]  t_out, t_oe_n, t_pin;
   logic [3:0]  t_func = 4'h0;
   logic        cfg_valid;
   logic [32:0] exp_q[$];
   int          bad_count = 0;
   int          total_checks = 0;
   rsc_pkg::rsc_init_status_t init_st = '0;
   rsc_pkg::rsc_cfg_t         cfg;

   always #2.5 pclk = ~pclk;

   rsc_top #(.SETTLE(SETTLE)) rsc_top_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_status_bus_in(s_pin), .strap_status_bus_out(s_out),
      .strap_status_bus_oe_n(s_oe_n), .port_tx_enable_in(t_pin),
      .port_tx_enable_out(t_out), .port_tx_enable_oe_n(t_oe_n),
      .port_tx_enable_func(t_func), .init_status(init_st), .cfg(cfg),
      .cfg_valid(cfg_valid));
   rsc_board rsc_board_inst (.pull_s(pull_s), .s_out(s_out),
      .s_oe_n(s_oe_n), .s_pin(s_pin), .pull_t(pull_t), .t_out(t_out),
      .t_oe_n(t_oe_n), .t_pin(t_pin));

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (!pready) begin
         bad_count++;
         wrap_up();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Scoreboard on completed reads
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         check({pslverr, prdata}, exp_q.pop_front());
      end
   end

   initial begin
      logic [15:0] s;
      logic [3:0]  t;
      logic [32:0] c;
      logic        f;
      int          n;
      n = $urandom(32'h60bc);
      for (int i = 0; i < 6; i++) begin
         s = (16'($urandom()) & 16'h1af9) | 16'he106;
         s = (i == 0) ? 16'he106 : (i == 1) ? 16'hfbff : s;
         s = (i == 5) ? (s | 16'h0400) : s;
         t = 4'($urandom());
         f = (s[2:1] != 2'h3) || !s[8] || (s[15:13] != 3'h7) || s[10];
         c = 33'({s[0], s[3], s[6:4], s[7], s[9], s[11], s[12], t});
         pull_s <= s;
         pull_t <= t;
         presetn <= 1'b0;
         repeat (4) @(posedge pclk);
         presetn <= 1'b1;
         n = 0;
         while (!cfg_valid && n < 100) begin
            @(posedge pclk);
            n++;
         end
         if (!cfg_valid) begin
            bad_count++;
            wrap_up();
         end
         @(posedge pclk);
         check(33'(cfg), c);
         pull_s <= ~s;
         pull_t <= ~t;
         rd(rsc_pkg::ADDR_CFG, c);
         rd(rsc_pkg::ADDR_USER, 33'(t));
         rd(rsc_pkg::ADDR_RAW, 33'(s));
         rd(rsc_pkg::ADDR_STAT, 33'({f, 1'b1}) | 33'h4);
         apb(1'b1, rsc_pkg::ADDR_CFG, 32'hffffffff);
         rd(rsc_pkg::ADDR_CFG, c);
         init_st <= 4'($urandom());
         t_func <= 4'($urandom());
         repeat (3) @(posedge pclk);
         check(33'(s_pin), 33'(init_st));
         check(33'(t_pin), 33'(t_func));
         apb(1'b1, rsc_pkg::ADDR_CTRL, 32'(i % 3));
         rd(rsc_pkg::ADDR_CTRL, 33'(i % 3));
         repeat (2) @(posedge pclk);
         c = (i % 3 == 1) ? 33'(init_st) : {17'h0, ~s};
         check(33'(s_pin), c);
         c = (i % 3 == 2) ? 33'(t_func) : {29'h0, ~t};
         check(33'(t_pin), c);
         apb(1'b1, rsc_pkg::ADDR_CTRL, 32'h3);
         rd(8'h14, 33'h100000000);
         rd(rsc_pkg::ADDR_CTRL, 33'h3);
      end
      wrap_up();
   end
endmodule
